// ==== dgp_top.sv ====
// Dual GPIO port bank with APB register access and pin availability gating.
// Assumes oscillator, debug and reset-pin qualifiers are synchronous levels.
//
// Design decision made here: the APB slave port.
module dgp_top
   import dgp_pkg::*;
#(
   parameter bit PIN20 = 1'b0
)
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                pclk_en,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                reset_pin_enable,
   input  wire logic [1:0]          primary_osc_mode,
   input  wire logic                clock_out_pin_select,
   input  wire logic                debug_pair_two_active,
   input  wire logic                debug_pair_three_active,
   input  wire logic                emu_pair_one_active,
   input  wire logic                emu_pair_three_active,
   input  wire logic [PORT_A_W-1:0] pa_in,
   output logic      [PORT_A_W-1:0] pa_out,
   output logic      [PORT_A_W-1:0] pa_oe,
   input  wire logic [PORT_B_W-1:0] pb_in,
   output logic      [PORT_B_W-1:0] pb_out,
   output logic      [PORT_B_W-1:0] pb_oe,
   output logic                     two_wire_input_delay,
   output logic                     compare_output_tristate,
   output logic                     clock_seconds_select_hi,
   output logic                     clock_seconds_select_lo
);
   localparam logic [15:0] A_MASK = PIN20 ? (A_IMPL & ~A_DROP20) : A_IMPL;
   localparam logic [15:0] B_MASK = PIN20 ? (B_IMPL & ~B_DROP20) : B_IMPL;

   logic      [31:0] prdata_reg;
   logic             pready_reg;
   logic             pslverr_reg;
   logic      [15:0] pad_reg;
   logic      [15:0] a_dir;
   logic      [15:0] a_lat;
   logic      [15:0] a_od;
   logic      [15:0] b_dir;
   logic      [15:0] b_lat;
   logic      [15:0] b_od;

   wire logic [IDX_W-1:0] idx;
   wire logic        first_acc;
   wire logic        commit;
   wire logic        do_wr;
   wire logic        hit;
   wire logic        osc_a2_ok;
   wire logic        osc_a3_ok;
   wire logic [15:0] a_avail;
   wire logic [15:0] b_avail;
   wire logic [15:0] a_pin_mask;
   wire logic [15:0] b_pin_mask;
   wire logic [15:0] a_pin_rd;
   wire logic [15:0] b_pin_rd;
   wire logic [15:0] rd_mux;
   wire logic [15:0] pad_wmask;
   wire logic [15:0] pad_next;

   // APB decode
   assign idx       = paddr[ADDR_W-1:2];
   assign first_acc = psel & penable & ~pready_reg;
   assign commit    = psel & penable & pready_reg;
   assign do_wr     = commit & pwrite & ~pslverr_reg;
   assign hit       = (idx == IDX_A_DIR) | (idx == IDX_A_PIN) | (idx == IDX_A_LAT)
                    | (idx == IDX_A_OD)  | (idx == IDX_B_DIR) | (idx == IDX_B_PIN)
                    | (idx == IDX_B_LAT) | (idx == IDX_B_OD)  | (idx == IDX_PAD);

   assign osc_a2_ok = (primary_osc_mode == OSC_OFF);
   // oscillator and clock out qualify bit 3
   assign osc_a3_ok = ((primary_osc_mode == OSC_OFF) | (primary_osc_mode == OSC_EXT_CLK))
                    & ~clock_out_pin_select;
   assign a_avail   = A_MASK & ~(osc_a2_ok ? NONE_MASK : A_BIT2)
                    & ~(osc_a3_ok ? NONE_MASK : A_BIT3);
   assign b_avail   = B_MASK;

   // bit 5 with reset pin off
   // debug pair two hides bits 1 and 0
   // debug pair three hides bit 4
   assign a_pin_mask = (a_avail | (reset_pin_enable ? NONE_MASK : A_BIT5))
                     & ~(debug_pair_two_active ? BITS_10 : NONE_MASK)
                     & ~(debug_pair_three_active ? BIT4 : NONE_MASK);
   // emulation pair one hides bits 1 and 0
   // emulation pair three hides bit 4
   assign b_pin_mask = b_avail
                     & ~(emu_pair_one_active ? BITS_10 : NONE_MASK)
                     & ~(emu_pair_three_active ? BIT4 : NONE_MASK);

   assign a_pin_rd = {8'h00, pa_in} & a_pin_mask;
   assign b_pin_rd = pb_in & b_pin_mask;

   assign rd_mux = (idx == IDX_A_DIR) ? (a_dir & a_avail) :
                   (idx == IDX_A_PIN) ? a_pin_rd :
                   (idx == IDX_A_LAT) ? (a_lat & a_avail) :
                   (idx == IDX_A_OD)  ? (a_od & a_avail) :
                   (idx == IDX_B_DIR) ? (b_dir & b_avail) :
                   (idx == IDX_B_PIN) ? b_pin_rd :
                   (idx == IDX_B_LAT) ? (b_lat & b_avail) :
                   (idx == IDX_B_OD)  ? (b_od & b_avail) :
                   (idx == IDX_PAD)   ? (pad_reg & PAD_IMPL) : 16'h0000;

   // pad writes limited to implemented fields
   assign pad_wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & PAD_IMPL;
   assign pad_next  = (pad_reg & ~pad_wmask) | (pwdata[15:0] & pad_wmask);

   // APB answer: one wait state, data and error registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end
      else if (pclk_en)
      begin
         pready_reg  <= first_acc;
         pslverr_reg <= first_acc & ~hit;
         if (first_acc)
            prdata_reg <= {16'h0000, (pwrite ? 16'h0000 : rd_mux)};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pad_reg <= PAD_RST;
      else if (pclk_en && do_wr && idx == IDX_PAD)
         pad_reg <= pad_next;
   end

   assign prdata                  = prdata_reg;
   assign pready                  = pready_reg;
   assign pslverr                 = pslverr_reg;
   assign two_wire_input_delay    = pad_reg[PAD_DLY_POS];
   assign compare_output_tristate = pad_reg[PAD_OCT_POS];
   assign clock_seconds_select_hi = pad_reg[PAD_SHI_POS];
   assign clock_seconds_select_lo = pad_reg[PAD_SLO_POS];

   // port A direction resets to 00df, 005f in 20-pin
   // port A bit 7 absent in 20-pin
   dgp_port #(
      .WIDTH   (PORT_A_W),
      .DIR_RST (A_DIR_RST),
      .IMPL    (A_MASK)
   ) u_port_a (
      .pclk        (pclk),
      .presetn     (presetn),
      .ce          (pclk_en),
      .wr_dir      (do_wr && idx == IDX_A_DIR),
      .wr_lat      (do_wr && (idx == IDX_A_LAT || idx == IDX_A_PIN)),
      .wr_od       (do_wr && idx == IDX_A_OD),
      .wbe         (pstrb[1:0]),
      .wdata       (pwdata[15:0]),
      .avail       (a_avail),
      .dir_reg     (a_dir),
      .lat_reg     (a_lat),
      .od_reg      (a_od),
      .pad_out_reg (pa_out),
      .pad_oe_reg  (pa_oe)
   );

   // port B direction resets to ffff, f397 in 20-pin
   // port B bits absent in 20-pin
   dgp_port #(
      .WIDTH   (PORT_B_W),
      .DIR_RST (B_DIR_RST),
      .IMPL    (B_MASK)
   ) u_port_b (
      .pclk        (pclk),
      .presetn     (presetn),
      .ce          (pclk_en),
      .wr_dir      (do_wr && idx == IDX_B_DIR),
      .wr_lat      (do_wr && (idx == IDX_B_LAT || idx == IDX_B_PIN)),
      .wr_od       (do_wr && idx == IDX_B_OD),
      .wbe         (pstrb[1:0]),
      .wdata       (pwdata[15:0]),
      .avail       (b_avail),
      .dir_reg     (b_dir),
      .lat_reg     (b_lat),
      .od_reg      (b_od),
      .pad_out_reg (pb_out),
      .pad_oe_reg  (pb_oe)
   );

   // Assertions
   ready_pulse_a : assert property (@(posedge pclk) disable iff (!presetn)
      (pclk_en && first_acc) |=> (pready && $past(pready) == 1'b0))
      else $error("pready not raised after first access cycle");

   pad_unimpl_a : assert property (@(posedge pclk) disable iff (!presetn)
      (pready && !pwrite && idx == IDX_PAD) |-> (prdata[31:5] == 27'h0 && !prdata[0]))
      else $error("pad register unimplemented bit reads nonzero");

   reset_vals_a : assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (a_dir == (A_DIR_RST & A_MASK) && b_dir == (B_DIR_RST & B_MASK)
                          && a_od == OD_RST && b_od == OD_RST && pad_reg == PAD_RST))
      else $error("reset values wrong");

   a_bit5_a : assert property (@(posedge pclk) disable iff (!presetn)
      (pclk_en && first_acc && !pwrite && idx == IDX_A_PIN && reset_pin_enable)
      |=> !prdata[5])
      else $error("port A bit 5 readable with reset pin enabled");

   a_dbg_a : assert property (@(posedge pclk) disable iff (!presetn)
      (pclk_en && first_acc && !pwrite && idx == IDX_A_PIN && debug_pair_two_active)
      |=> (prdata[1:0] == 2'b00))
      else $error("port A bits 1:0 visible during debug pair two");

   a_dbg3_a : assert property (@(posedge pclk) disable iff (!presetn)
      (pclk_en && first_acc && !pwrite && idx == IDX_A_PIN && debug_pair_three_active)
      |=> !prdata[4])
      else $error("port A bit 4 visible during debug pair three");

   b_emu1_a : assert property (@(posedge pclk) disable iff (!presetn)
      (pclk_en && first_acc && !pwrite && idx == IDX_B_PIN && emu_pair_one_active)
      |=> (prdata[1:0] == 2'b00))
      else $error("port B bits 1:0 visible during emulation pair one");

   b_emu3_a : assert property (@(posedge pclk) disable iff (!presetn)
      (pclk_en && first_acc && !pwrite && idx == IDX_B_PIN && emu_pair_three_active)
      |=> !prdata[4])
      else $error("port B bit 4 visible during emulation pair three");

   osc_bit2_a : assert property (@(posedge pclk) disable iff (!presetn)
      (pclk_en && primary_osc_mode != OSC_OFF) |=> !pa_oe[2])
      else $error("port A bit 2 driven with oscillator on");

   osc_bit3_a : assert property (@(posedge pclk) disable iff (!presetn)
      (pclk_en && (clock_out_pin_select || primary_osc_mode == 2'b01
                   || primary_osc_mode == 2'b10)) |=> !pa_oe[3])
      else $error("port A bit 3 driven while claimed by oscillator");

   a_pin20_a : assert property (@(posedge pclk) disable iff (!presetn)
      PIN20 |-> (!pa_oe[7] && !a_dir[7] && !a_lat[7] && !a_od[7]))
      else $error("port A bit 7 present in 20-pin variant");

   b_pin20_a : assert property (@(posedge pclk) disable iff (!presetn)
      PIN20 |-> ((pb_oe & B_DROP20) == 16'h0000 && (b_lat & B_DROP20) == 16'h0000))
      else $error("port B absent bit present in 20-pin variant");

   pin_level_a : assert property (@(posedge pclk) disable iff (!presetn)
      (pclk_en && first_acc && !pwrite && idx == IDX_B_PIN && !emu_pair_one_active)
      |=> (prdata[0] == $past(pb_in[0])))
      else $error("port B pin read does not match pin level");
endmodule : dgp_top

// ==== dgp_pkg.sv ====
// Constants for the dual GPIO port bank: register indices, masks, resets.
// Assumes a 32-bit APB slave; byte address is four times the register index.
package dgp_pkg;
   localparam int          ADDR_W       = 12;
   localparam int          IDX_W        = 10;

   // Register indices (byte address = index * 4)
   localparam logic [9:0]  IDX_A_DIR    = 10'h2c0;
   localparam logic [9:0]  IDX_A_PIN    = 10'h2c2;
   localparam logic [9:0]  IDX_A_LAT    = 10'h2c4;
   localparam logic [9:0]  IDX_A_OD     = 10'h2c6;
   localparam logic [9:0]  IDX_B_DIR    = 10'h2c8;
   localparam logic [9:0]  IDX_B_PIN    = 10'h2ca;
   localparam logic [9:0]  IDX_B_LAT    = 10'h2cc;
   localparam logic [9:0]  IDX_B_OD     = 10'h2ce;
   localparam logic [9:0]  IDX_PAD      = 10'h2fc;

   // Reset values
   localparam logic [15:0] A_DIR_RST    = 16'h00df;
   localparam logic [15:0] B_DIR_RST    = 16'hffff;
   localparam logic [15:0] LAT_RST      = 16'h0000;
   localparam logic [15:0] OD_RST       = 16'h0000;
   localparam logic [15:0] PAD_RST      = 16'h0000;

   // Implemented bit masks
   localparam logic [15:0] A_IMPL       = 16'h00df;
   localparam logic [15:0] A_DROP20     = 16'h0080;
   localparam logic [15:0] B_IMPL       = 16'hffff;
   localparam logic [15:0] B_DROP20     = 16'h0c68;
   localparam logic [15:0] PAD_IMPL     = 16'h001e;
   localparam logic [15:0] NONE_MASK    = 16'h0000;

   // Qualified bits
   localparam logic [15:0] A_BIT5       = 16'h0020;
   localparam logic [15:0] A_BIT2       = 16'h0004;
   localparam logic [15:0] A_BIT3       = 16'h0008;
   localparam logic [15:0] BITS_10      = 16'h0003;
   localparam logic [15:0] BIT4         = 16'h0010;

   // Oscillator modes
   localparam logic [1:0]  OSC_OFF      = 2'b00;
   localparam logic [1:0]  OSC_EXT_CLK  = 2'b11;

   // Pad configuration field positions
   localparam int          PAD_DLY_POS  = 4;
   localparam int          PAD_OCT_POS  = 3;
   localparam int          PAD_SHI_POS  = 2;
   localparam int          PAD_SLO_POS  = 1;

   localparam int          PORT_A_W     = 8;
   localparam int          PORT_B_W     = 16;
endpackage : dgp_pkg

// ==== dgp_port.sv ====
// One GPIO port: direction, output latch and open-drain registers and pad drive.
// Assumes writes arrive as single-cycle strobes with byte enables.
module dgp_port
   import dgp_pkg::*;
#(
   parameter int          WIDTH   = 16,
   parameter logic [15:0] DIR_RST = 16'hffff,
   parameter logic [15:0] IMPL    = 16'hffff
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic             wr_dir,
   input  wire logic             wr_lat,
   input  wire logic             wr_od,
   input  wire logic [1:0]       wbe,
   input  wire logic [15:0]      wdata,
   input  wire logic [15:0]      avail,
   output logic      [15:0]      dir_reg,
   output logic      [15:0]      lat_reg,
   output logic      [15:0]      od_reg,
   output logic      [WIDTH-1:0] pad_out_reg,
   output logic      [WIDTH-1:0] pad_oe_reg
);
   wire logic [15:0] wmask;
   wire logic [15:0] dir_next;
   wire logic [15:0] lat_next;
   wire logic [15:0] od_next;
   wire logic [15:0] out_next;
   wire logic [15:0] oe_next;

   assign wmask    = {{8{wbe[1]}}, {8{wbe[0]}}} & IMPL;
   assign dir_next = (dir_reg & ~wmask) | (wdata & wmask);
   assign lat_next = (lat_reg & ~wmask) | (wdata & wmask);
   assign od_next  = (od_reg & ~wmask) | (wdata & wmask);
   assign out_next = lat_reg & ~od_reg;
   assign oe_next  = ~dir_reg & avail & (~od_reg | ~lat_reg);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dir_reg     <= DIR_RST & IMPL;
         lat_reg     <= LAT_RST;
         od_reg      <= OD_RST;
         pad_out_reg <= '0;
         pad_oe_reg  <= '0;
      end
      else if (ce)
      begin
         if (wr_dir)
            dir_reg <= dir_next;
         if (wr_lat)
            lat_reg <= lat_next;
         if (wr_od)
            od_reg <= od_next;
         pad_out_reg <= out_next[WIDTH-1:0];
         pad_oe_reg  <= oe_next[WIDTH-1:0];
      end
   end

   dir_input_a : assert property (@(posedge pclk) disable iff (!presetn)
      (ce && dir_reg[0]) |=> !pad_oe_reg[0])
      else $error("pad driven while direction is input");

   od_high_a : assert property (@(posedge pclk) disable iff (!presetn)
      (ce && od_reg[0] && lat_reg[0]) |=> (!pad_oe_reg[0] && !pad_out_reg[0]))
      else $error("open-drain pad driven high");

   push_pull_a : assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !od_reg[0] && !dir_reg[0] && avail[0]) |=>
      (pad_oe_reg[0] && pad_out_reg[0] == $past(lat_reg[0])))
      else $error("push-pull pad not following latch");
endmodule : dgp_port

// ==== dgp_pins.sv ====
// Far-side pin model for the GPIO bank: external drivers and pull-ups.
// Assumes the bank drives a pin only while its output enable is high.
module dgp_pins
   import dgp_pkg::*;
(
   input  wire logic [PORT_A_W-1:0] pa_out,
   input  wire logic [PORT_A_W-1:0] pa_oe,
   input  wire logic [PORT_B_W-1:0] pb_out,
   input  wire logic [PORT_B_W-1:0] pb_oe,
   input  wire logic [PORT_A_W-1:0] ext_a,
   input  wire logic [PORT_B_W-1:0] ext_b,
   input  wire logic                ext_en,
   output logic      [PORT_A_W-1:0] pa_pin,
   output logic      [PORT_B_W-1:0] pb_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   assign pa_pin = (pa_oe & pa_out) | (~pa_oe & (ext_en ? ext_a : {PORT_A_W{1'b1}}));
   assign pb_pin = (pb_oe & pb_out) | (~pb_oe & (ext_en ? ext_b : {PORT_B_W{1'b1}}));
endmodule : dgp_pins

// ==== dgp_top_tb.sv ====
// Self-checking bench for the GPIO bank: full and 20-pin variants side by side.
// Assumes the pin model drives the pad inputs of both instances.
module dgp_top_tb
   import dgp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0]   paddr = '0;
   logic [31:0]         pwdata = '0, prdata, prdata20;
   logic                pready, pslverr, ext_en = 1'b0;
   logic                reset_pin_enable = 1'b0, clock_out_pin_select = 1'b0;
   logic [1:0]          primary_osc_mode = 2'b00;
   logic                debug_pair_two_active = 1'b0, debug_pair_three_active = 1'b0;
   logic                emu_pair_one_active = 1'b0, emu_pair_three_active = 1'b0;
   logic [PORT_A_W-1:0] pa_out, pa_oe, pa_pin, ext_a = '0;
   logic [PORT_B_W-1:0] pb_out, pb_oe, pb_pin, ext_b = '0;
   logic                tw_dly, cmp_tri, sec_hi, sec_lo;
   logic                pclk_en = 1'b1;
   logic [3:0]          pstrb = 4'hf;
   int                  fails = 0, tests_run = 0;

   always #2.5 pclk = ~pclk;

   dgp_top #(.PIN20(1'b0)) u_dgp_top (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reset_pin_enable(reset_pin_enable), .primary_osc_mode(primary_osc_mode),
      .clock_out_pin_select(clock_out_pin_select),
      .debug_pair_two_active(debug_pair_two_active),
      .debug_pair_three_active(debug_pair_three_active),
      .emu_pair_one_active(emu_pair_one_active), .emu_pair_three_active(emu_pair_three_active),
      .pa_in(pa_pin), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_pin), .pb_out(pb_out),
      .pb_oe(pb_oe), .two_wire_input_delay(tw_dly), .compare_output_tristate(cmp_tri),
      .clock_seconds_select_hi(sec_hi), .clock_seconds_select_lo(sec_lo));

   dgp_top #(.PIN20(1'b1)) u_dgp_top_p20 (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata20), .pready(), .pslverr(),
      .reset_pin_enable(reset_pin_enable), .primary_osc_mode(primary_osc_mode),
      .clock_out_pin_select(clock_out_pin_select),
      .debug_pair_two_active(debug_pair_two_active),
      .debug_pair_three_active(debug_pair_three_active),
      .emu_pair_one_active(emu_pair_one_active), .emu_pair_three_active(emu_pair_three_active),
      .pa_in(pa_pin), .pa_out(), .pa_oe(), .pb_in(pb_pin), .pb_out(), .pb_oe(),
      .two_wire_input_delay(), .compare_output_tristate(), .clock_seconds_select_hi(),
      .clock_seconds_select_lo());

   dgp_pins u_dgp_pins (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
      .ext_a(ext_a), .ext_b(ext_b), .ext_en(ext_en), .pa_pin(pa_pin), .pb_pin(pb_pin));

   task automatic give_verdict;
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      tests_run++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd,
                      output logic [15:0] rd, output logic [15:0] rd20, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {16'h0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            fails++;
            $display("mismatch pready expected 1 seen 0");
            give_verdict();
         end
         @(posedge pclk);
      end
      rd      = prdata[15:0];
      rd20    = prdata20[15:0];
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [9:0] idx, input logic [15:0] d);
      logic [15:0] r, r20;
      logic        err;
      apb(1'b1, idx, d, r, r20, err);
   endtask : wr

   task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [15:0] e,
                         input logic [15:0] e20);
      logic [15:0] r, r20;
      logic        err;
      apb(1'b0, idx, 16'h0000, r, r20, err);
      chk(nm, e, r);
      chk({nm, "_p20"}, e20, r20);
      chk({nm, "_err"}, 16'h0000, {15'h0000, err});
   endtask : rd_chk

   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle

   task automatic t_reset;
      rd_chk("a_dir", IDX_A_DIR, 16'h00df, 16'h005f);
      rd_chk("b_dir", IDX_B_DIR, 16'hffff, 16'hf397);
      rd_chk("a_od", IDX_A_OD, 16'h0000, 16'h0000);
      rd_chk("b_od", IDX_B_OD, 16'h0000, 16'h0000);
      rd_chk("pad", IDX_PAD, 16'h0000, 16'h0000);
   endtask : t_reset

   task automatic t_masks;
      logic [15:0] r, r20;
      logic        err;
      wr(IDX_A_DIR, 16'hffff);
      rd_chk("a_dir", IDX_A_DIR, 16'h00df, 16'h005f);
      wr(IDX_B_OD, 16'hffff);
      rd_chk("b_od", IDX_B_OD, 16'hffff, 16'hf397);
      wr(IDX_PAD, 16'hffff);
      rd_chk("pad", IDX_PAD, 16'h001e, 16'h001e);
      settle();
      chk("pad_pins", 16'h000f, {12'h000, tw_dly, cmp_tri, sec_hi, sec_lo});
      apb(1'b0, 10'h2d0, 16'h0000, r, r20, err);
      chk("unmapped_err", 16'h0001, {15'h0000, err});
      chk("unmapped_data", 16'h0000, r);
      pstrb <= 4'h1;
      wr(IDX_B_LAT, 16'h1234);
      pstrb <= 4'hf;
      rd_chk("b_lat_lane", IDX_B_LAT, 16'h0034, 16'h0014);
      wr(IDX_B_OD, 16'h0000);
   endtask : t_masks

   task automatic t_drive;
      wr(IDX_A_DIR, 16'h0000);
      wr(IDX_A_LAT, 16'h000f);
      wr(IDX_B_DIR, 16'h0000);
      wr(IDX_B_LAT, 16'ha5a5);
      settle();
      chk("pa_oe", 16'h00df, {8'h00, pa_oe});
      chk("pa_out", 16'h000f, {8'h00, pa_out});
      chk("pb_oe", 16'hffff, pb_oe);
      chk("pb_out", 16'ha5a5, pb_out);
      rd_chk("a_pin", IDX_A_PIN, 16'h002f, 16'h002f);
      wr(IDX_A_OD, 16'h00ff);
      settle();
      chk("pa_oe_od", 16'h00d0, {8'h00, pa_oe});
      chk("pa_out_od", 16'h0000, {8'h00, pa_out});
      wr(IDX_A_DIR, 16'hffff);
      wr(IDX_B_DIR, 16'hffff);
   endtask : t_drive

   // oscillator claims drive, clock enable freezes it
   task automatic t_osc_drive;
      wr(IDX_A_OD, 16'h0000);
      wr(IDX_A_DIR, 16'h0000);
      pclk_en          <= 1'b0;
      primary_osc_mode <= 2'b01;
      settle();
      chk("pa_oe_frozen", 16'h0000, {8'h00, pa_oe});
      @(posedge pclk);
      pclk_en <= 1'b1;
      settle();
      chk("pa_oe_osc", 16'h00d3, {8'h00, pa_oe});
      chk("pa_out_osc", 16'h000f, {8'h00, pa_out});
      @(posedge pclk);
      primary_osc_mode     <= 2'b00;
      clock_out_pin_select <= 1'b0;
      settle();
      chk("pa_oe_free", 16'h00df, {8'h00, pa_oe});
   endtask : t_osc_drive

   task automatic q(input logic rp, input logic [1:0] osc, input logic co,
                    input logic [3:0] dbg, input logic [15:0] ea, input logic [15:0] eb);
      @(posedge pclk);
      reset_pin_enable     <= rp;
      primary_osc_mode     <= osc;
      clock_out_pin_select <= co;
      {debug_pair_two_active, debug_pair_three_active} <= dbg[3:2];
      {emu_pair_one_active, emu_pair_three_active}     <= dbg[1:0];
      rd_chk("a_pin", IDX_A_PIN, ea, ea & ~A_DROP20);
      rd_chk("b_pin", IDX_B_PIN, eb, eb & ~B_DROP20);
   endtask : q

   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_masks();
      t_drive();
      ext_en <= 1'b1;
      ext_a  <= 8'hff;
      ext_b  <= 16'hffff;
      q(1'b0, 2'b00, 1'b0, 4'h0, 16'h00ff, 16'hffff);
      q(1'b1, 2'b00, 1'b0, 4'h0, 16'h00df, 16'hffff);
      q(1'b0, 2'b00, 1'b0, 4'h8, 16'h00fc, 16'hffff);
      q(1'b0, 2'b00, 1'b0, 4'h4, 16'h00ef, 16'hffff);
      q(1'b0, 2'b00, 1'b0, 4'h2, 16'h00ff, 16'hfffc);
      q(1'b0, 2'b00, 1'b0, 4'h1, 16'h00ff, 16'hffef);
      q(1'b0, 2'b01, 1'b0, 4'h0, 16'h00f3, 16'hffff);
      q(1'b0, 2'b10, 1'b0, 4'h0, 16'h00f3, 16'hffff);
      q(1'b0, 2'b11, 1'b0, 4'h0, 16'h00fb, 16'hffff);
      q(1'b0, 2'b11, 1'b1, 4'h0, 16'h00f3, 16'hffff);
      q(1'b0, 2'b00, 1'b1, 4'h0, 16'h00f7, 16'hffff);
      t_osc_drive();
      wr(IDX_A_DIR, 16'h0000);
      wr(IDX_PAD, 16'hffff);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      settle();
      chk("pa_oe_rst", 16'h0000, {8'h00, pa_oe});
      chk("pad_pins_rst", 16'h0000, {12'h000, tw_dly, cmp_tri, sec_hi, sec_lo});
      give_verdict();
   end
endmodule : dgp_top_tb
